// File: hw/cdsp_cfg.svh
// constants of the serial control and status port
`ifndef CDSP_CFG_SVH
`define CDSP_CFG_SVH
`define CDSP_CLK_HZ            50000000
`define CDSP_LOCK_SAMPLE_HZ    460
`define CDSP_LOCK_DIV          (`CDSP_CLK_HZ / `CDSP_LOCK_SAMPLE_HZ)
`define CDSP_LOCK_LOW_SAMPLES  8
`define CDSP_SUBQ_BITS         80
`define CDSP_LEVEL_BITS        16
`define CDSP_CMD_BITS          24
`define CDSP_PW_BITS           8
`define CDSP_SENSE_BITS        8
`define CDSP_LOCK_RST          1'b0
`endif

// File: hw/cdsp_pkg.sv
// shared types of the serial control and status port
`include "cdsp_cfg.svh"
package cdsp_pkg;
    typedef logic [`CDSP_SUBQ_BITS+`CDSP_LEVEL_BITS-1:0] cdsp_subq_rec_type;
    typedef logic [2:0]                                 cdsp_sync_type;
endpackage : cdsp_pkg

// File: hw/cdsp_host_link.sv
// host serial command input, three readout streams, lock and sync flags
`timescale 1ns/1ps
`include "cdsp_cfg.svh"

// Functional notes
// - system-domain registers reset while the active-low system reset pin is low; the link shift register is not reset
// - host shifts command bits in on data pin under its own transfer clock
// - command word taken into internal registers at latch strobe falling edge
// - sub-Q stream is 80 sub-Q bits followed by 16 peak/level bits
// - sub-Q stream advances only on host readout clock
// - P-W subcode stream advances one bit per host readout clock rising edge
// - sense pin shows status, shifts serial sense data under host clock
// - defect guard disable high turns the defect countermeasure off
// - frame-sync-good sampled at 460 Hz; high sample drives lock high
// - lock falls only after eight consecutive low samples
// - frame-sync-good is detected sync coinciding with protection window
// - subcode sync flag high when S0 or S1 pattern detected
module cdsp_host_link
    import cdsp_pkg::*;
#(
    parameter int CMD_BITS   = `CDSP_CMD_BITS,
    parameter int PW_BITS    = `CDSP_PW_BITS,
    parameter int SENSE_BITS = `CDSP_SENSE_BITS,
    parameter int LOCK_DIV   = `CDSP_LOCK_DIV
)
(
    // system clock and reset
    input  wire logic                    CLK_I,
    input  wire logic                    RST_N_I,
    // host pins
    input  wire logic                    SYSTEM_RESET_N_I,
    input  wire logic                    CMD_SHIFT_CLK_I,
    input  wire logic                    CMD_DATA_I,
    input  wire logic                    CMD_LATCH_STROBE_I,
    input  wire logic                    SUBQ_READ_CLK_I,
    input  wire logic                    SUBCODE_PW_READ_CLK_I,
    input  wire logic                    SENSE_READ_CLK_I,
    input  wire logic                    DEFECT_GUARD_DISABLE_I,
    output logic                         SUBQ_SERIAL_OUT_O,
    output logic                         SUBCODE_PW_SERIAL_OUT_O,
    output logic                         SENSE_OUT_O,
    output logic                         LOCK_O,
    output logic                         SUBCODE_SYNC_FLAG_O,
    // core side
    input  wire logic [`CDSP_SUBQ_BITS-1:0]  SUBQ_DATA_I,
    input  wire logic [`CDSP_LEVEL_BITS-1:0] LEVEL_DATA_I,
    input  wire logic                    SUBQ_LOAD_I,
    input  wire logic [PW_BITS-1:0]      PW_DATA_I,
    input  wire logic                    PW_LOAD_I,
    input  wire logic [SENSE_BITS-1:0]   SENSE_DATA_I,
    input  wire logic                    SENSE_LOAD_I,
    input  wire logic                    SENSE_LEVEL_I,
    input  wire logic                    DISC_DEFECT_I,
    input  wire logic                    FRAME_SYNC_DET_I,
    input  wire logic                    PROTECT_WINDOW_I,
    input  wire logic                    SYNC_S0_DET_I,
    input  wire logic                    SYNC_S1_DET_I,
    output logic [CMD_BITS-1:0]          CMD_WORD_O,
    output logic                         CMD_STROBE_O,
    output logic                         DEFECT_GUARD_O,
    output logic                         SYSTEM_RESET_O
);

    localparam int SUBQ_W  = `CDSP_SUBQ_BITS + `CDSP_LEVEL_BITS;
    localparam int DIV_W   = $clog2(LOCK_DIV + 1);
    localparam int SCNT_W  = $clog2(SENSE_BITS + 1);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(LOCK_DIV - 1);
    localparam logic [3:0]        LOW_LAST  = 4'(`CDSP_LOCK_LOW_SAMPLES - 1);
    localparam logic [SCNT_W-1:0] SENSE_CNT = SCNT_W'(SENSE_BITS);

    typedef struct packed {
        logic [1:0]          rst_sync;
        cdsp_sync_type       strobe_sync;
        cdsp_sync_type       subq_sync;
        cdsp_sync_type       pw_sync;
        cdsp_sync_type       sense_sync;
        logic [1:0]          dis_sync;
        logic [CMD_BITS-1:0] cmd_word;
        logic                cmd_strobe;
        cdsp_subq_rec_type   subq_sh;
        logic [PW_BITS-1:0]  pw_sh;
        logic [SENSE_BITS-1:0] sense_sh;
        logic [SCNT_W-1:0]   sense_cnt;
        logic                sense_out;
        logic [DIV_W-1:0]    div_cnt;
        logic                tick;
        logic [3:0]          low_cnt;
        logic                lock;
        logic                frame_sync_good;
        logic                subcode_sync_flag;
        logic                guard;
        logic                sys_rst;
    } cdsp_sys_state_type;

    typedef struct packed {
        logic [CMD_BITS-1:0] cmd_sh;
    } cdsp_link_state_type;

    cdsp_sys_state_type  st;
    cdsp_sys_state_type  next_st;
    cdsp_link_state_type lk;
    cdsp_link_state_type next_lk;

    // rising edge of a synchronised host clock; never looks at stage one
    function automatic logic sync_rise(input cdsp_sync_type s);
        return s[1] & ~s[2];
    endfunction : sync_rise

    function automatic logic sync_fall(input cdsp_sync_type s);
        return ~s[1] & s[2];
    endfunction : sync_fall

    // link domain: shift register on the host transfer clock
    always_comb
    begin
        next_lk        = lk;
        next_lk.cmd_sh = {lk.cmd_sh[CMD_BITS-2:0], CMD_DATA_I};
    end

    always_ff @(posedge CMD_SHIFT_CLK_I)
    begin
        lk <= next_lk;
    end

    // system domain
    logic block_rst;
    assign block_rst = ~RST_N_I | st.sys_rst;

    always_comb
    begin
        next_st = st;
        next_st.rst_sync    = {st.rst_sync[0], SYSTEM_RESET_N_I};
        next_st.strobe_sync = {st.strobe_sync[1:0], CMD_LATCH_STROBE_I};
        next_st.subq_sync   = {st.subq_sync[1:0], SUBQ_READ_CLK_I};
        next_st.pw_sync     = {st.pw_sync[1:0], SUBCODE_PW_READ_CLK_I};
        next_st.sense_sync  = {st.sense_sync[1:0], SENSE_READ_CLK_I};
        next_st.dis_sync    = {st.dis_sync[0], DEFECT_GUARD_DISABLE_I};
        next_st.sys_rst     = ~st.rst_sync[1];
        next_st.cmd_strobe  = 1'b0;
        // the host stops its transfer clock before dropping the strobe, so the
        // link shift register is static when it is read here
        if (sync_fall(st.strobe_sync))
        begin
            next_st.cmd_word   = lk.cmd_sh;
            next_st.cmd_strobe = 1'b1;
        end
        if (SUBQ_LOAD_I)
        begin
            next_st.subq_sh = {SUBQ_DATA_I, LEVEL_DATA_I};
        end
        else if (sync_rise(st.subq_sync))
        begin
            next_st.subq_sh = {st.subq_sh[SUBQ_W-2:0], 1'b0};
        end
        if (PW_LOAD_I)
        begin
            next_st.pw_sh = PW_DATA_I;
        end
        else if (sync_rise(st.pw_sync))
        begin
            next_st.pw_sh = {st.pw_sh[PW_BITS-2:0], 1'b0};
        end
        if (SENSE_LOAD_I)
        begin
            next_st.sense_sh  = SENSE_DATA_I;
            next_st.sense_cnt = SENSE_CNT;
        end
        else if (sync_rise(st.sense_sync) && st.sense_cnt != '0)
        begin
            next_st.sense_sh  = {st.sense_sh[SENSE_BITS-2:0], 1'b0};
            next_st.sense_cnt = st.sense_cnt - 1'b1;
        end
        // idle sense pin shows the live status level
        next_st.sense_out = (next_st.sense_cnt != '0) ? next_st.sense_sh[SENSE_BITS-1]
                                                      : SENSE_LEVEL_I;
        next_st.guard = DISC_DEFECT_I & ~st.dis_sync[1];
        next_st.frame_sync_good   = FRAME_SYNC_DET_I & PROTECT_WINDOW_I;
        next_st.subcode_sync_flag  = SYNC_S0_DET_I | SYNC_S1_DET_I;
        next_st.tick  = 1'b0;
        if (st.div_cnt == DIV_LAST)
        begin
            next_st.div_cnt = '0;
            next_st.tick    = 1'b1;
        end
        else
        begin
            next_st.div_cnt = st.div_cnt + 1'b1;
        end
        if (st.tick)
        begin
            if (st.frame_sync_good)
            begin
                next_st.lock    = 1'b1;
                next_st.low_cnt = '0;
            end
            else if (st.low_cnt == LOW_LAST)
            begin
                next_st.lock    = 1'b0;
            end
            else
            begin
                next_st.low_cnt = st.low_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (block_rst)
        begin
            st          <= '0;
            st.lock     <= `CDSP_LOCK_RST;
            st.rst_sync <= next_st.rst_sync;
            st.sys_rst  <= next_st.sys_rst;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign SUBQ_SERIAL_OUT_O       = st.subq_sh[SUBQ_W-1];
    assign SUBCODE_PW_SERIAL_OUT_O = st.pw_sh[PW_BITS-1];
    assign SENSE_OUT_O             = st.sense_out;
    assign LOCK_O                  = st.lock;
    assign SUBCODE_SYNC_FLAG_O     = st.subcode_sync_flag;
    assign CMD_WORD_O              = st.cmd_word;
    assign CMD_STROBE_O            = st.cmd_strobe;
    assign DEFECT_GUARD_O          = st.guard;
    assign SYSTEM_RESET_O          = st.sys_rst;

    AST_PIN_RESET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !st.rst_sync[1] |=> ##1 (!LOCK_O && !CMD_STROBE_O && !SUBQ_SERIAL_OUT_O))
        else $error("pin reset did not clear the block");

    AST_LATCH_TAKE: assert property (@(posedge CLK_I) disable iff (block_rst)
        sync_fall(st.strobe_sync) |=> (CMD_STROBE_O && CMD_WORD_O == $past(lk.cmd_sh)))
        else $error("command word not taken at strobe fall");

    AST_LATCH_ONLY: assert property (@(posedge CLK_I) disable iff (block_rst)
        !sync_fall(st.strobe_sync) |=> (!CMD_STROBE_O && $stable(CMD_WORD_O)))
        else $error("command word changed without strobe fall");

    AST_SUBQ_RECORD: assert property (@(posedge CLK_I) disable iff (block_rst)
        SUBQ_LOAD_I |=> st.subq_sh == {$past(SUBQ_DATA_I), $past(LEVEL_DATA_I)})
        else $error("sub-Q record not loaded as 80 plus 16 bits");

    AST_SUBQ_SHIFT: assert property (@(posedge CLK_I) disable iff (block_rst)
        (!SUBQ_LOAD_I && !sync_rise(st.subq_sync)) |=> $stable(st.subq_sh))
        else $error("sub-Q stream moved without host clock");

    AST_PW_SHIFT: assert property (@(posedge CLK_I) disable iff (block_rst)
        (!PW_LOAD_I && sync_rise(st.pw_sync)) |=> SUBCODE_PW_SERIAL_OUT_O == $past(st.pw_sh[PW_BITS-2]))
        else $error("P-W stream did not advance one bit");

    AST_SENSE_SHIFT: assert property (@(posedge CLK_I) disable iff (block_rst)
        (!SENSE_LOAD_I && sync_rise(st.sense_sync) && st.sense_cnt > SCNT_W'(1))
        |=> SENSE_OUT_O == $past(st.sense_sh[SENSE_BITS-2]))
        else $error("sense data not shifted");

    AST_DEFECT_GUARD: assert property (@(posedge CLK_I) disable iff (block_rst)
        st.dis_sync[1] |=> !DEFECT_GUARD_O)
        else $error("defect guard active while disabled");

    AST_LOCK_SET: assert property (@(posedge CLK_I) disable iff (block_rst)
        (st.tick && st.frame_sync_good) |=> LOCK_O)
        else $error("lock not set by a high sample");

    AST_LOCK_HOLD: assert property (@(posedge CLK_I) disable iff (block_rst)
        (LOCK_O && !(st.tick && st.low_cnt == LOW_LAST)) |=> LOCK_O)
        else $error("lock dropped before eight low samples");

    AST_GFS_WINDOW: assert property (@(posedge CLK_I) disable iff (block_rst)
        (FRAME_SYNC_DET_I && !PROTECT_WINDOW_I) |=> !st.frame_sync_good)
        else $error("frame sync good outside protection window");

    AST_SYNC_FLAG: assert property (@(posedge CLK_I) disable iff (block_rst)
        (SYNC_S0_DET_I || SYNC_S1_DET_I) |=> SUBCODE_SYNC_FLAG_O)
        else $error("subcode sync flag missed");

    AST_LOCK_DROP: assert property (@(posedge CLK_I) disable iff (block_rst)
        (st.tick && !st.frame_sync_good && st.low_cnt == LOW_LAST) |=> !LOCK_O)
        else $error("lock held after eight low samples");

    AST_LOCK_COUNT: assert property (@(posedge CLK_I) disable iff (block_rst)
        (st.tick && st.frame_sync_good) |=> st.low_cnt == '0)
        else $error("low run count not cleared by a high sample");

    AST_SENSE_IDLE: assert property (@(posedge CLK_I) disable iff (block_rst)
        (!SENSE_LOAD_I && st.sense_cnt == '0) |=> SENSE_OUT_O == $past(SENSE_LEVEL_I))
        else $error("idle sense pin does not show the status level");

    AST_GUARD_ACTIVE: assert property (@(posedge CLK_I) disable iff (block_rst)
        !st.dis_sync[1] |=> DEFECT_GUARD_O == $past(DISC_DEFECT_I))
        else $error("defect guard does not follow the defect while enabled");

    AST_CMD_SHIFT: assert property (@(posedge CMD_SHIFT_CLK_I)
        1'b1 |=> lk.cmd_sh[0] == $past(CMD_DATA_I))
        else $error("command bit not captured on transfer clock rise");

endmodule : cdsp_host_link

// File: dv/cdsp_host_model.sv
// host microcontroller model on the serial command and readout pins
`timescale 1ns/1ps
module cdsp_host_model
(
    // pins toward the device
    output logic       shift_clk_o,
    output logic       data_o,
    output logic       strobe_o,
    output logic [2:0] read_clk_o,
    // device serial outputs: sub-Q, P-W, sense
    input  wire logic [2:0] so_i
);
    initial
    begin
        shift_clk_o = 1'b0;
        data_o      = 1'b0;
        strobe_o    = 1'b0;
        read_clk_o  = 3'h0;
    end
    // msb first; the transfer clock stands still outside the frame
    task automatic send_cmd(input logic [23:0] w);
        #7 strobe_o = 1'b1;
        for (int i = 23; i >= 0; i--)
        begin
            data_o = w[i];
            #40 shift_clk_o = 1'b1;
            #40 shift_clk_o = 1'b0;
        end
        data_o = ~data_o; // released line must not keep a stale bit
        #80 strobe_o = 1'b0;
        #160;
    endtask : send_cmd
    // low phase kept long so the synchronised bit has settled before sampling
    task automatic read_bits(input int sel, input int n, output logic [95:0] q);
        q = '0;
        #7;
        for (int i = 0; i < n; i++)
        begin
            q = {q[94:0], so_i[sel]};
            read_clk_o[sel] = 1'b1;
            #40 read_clk_o[sel] = 1'b0;
            #80;
        end
    endtask : read_bits
endmodule : cdsp_host_model

// File: dv/cdsp_host_link_tb.sv
// self-checking bench of the host serial control and status port
`timescale 1ns/1ps
module cdsp_host_link_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sys_rst_n = 1'b1;
    logic        dis = 1'b0;
    // 0..2 loads, 3 sense level, 4 defect, 5 sync det, 6 window, 7 s0, 8 s1
    logic [8:0]  ctl = 9'h008;
    logic [79:0] sq = 80'hF0E1D2C3B4A596870F1E;
    logic [15:0] lv = 16'h8001;
    logic [7:0]  pw = 8'hB4;
    logic [7:0]  sd = 8'h6D;
    logic [2:0]  so;
    logic [2:0]  rclk;
    logic [23:0] cmd_word;
    logic        sclk, sdat, stb, lock, subcode_sync_flag, cmd_stb, dguard, sys_rst_o;
    int          n_stb = 0;
    int          num_errors = 0;
    int          total_checks = 0;

    cdsp_host_link #(.LOCK_DIV(20)) dut (
        .CLK_I(clk), .RST_N_I(rst_n), .SYSTEM_RESET_N_I(sys_rst_n), .CMD_SHIFT_CLK_I(sclk),
        .CMD_DATA_I(sdat), .CMD_LATCH_STROBE_I(stb), .SUBQ_READ_CLK_I(rclk[0]),
        .SUBCODE_PW_READ_CLK_I(rclk[1]), .SENSE_READ_CLK_I(rclk[2]), .DEFECT_GUARD_DISABLE_I(dis),
        .SUBQ_SERIAL_OUT_O(so[0]), .SUBCODE_PW_SERIAL_OUT_O(so[1]), .SENSE_OUT_O(so[2]),
        .LOCK_O(lock), .SUBCODE_SYNC_FLAG_O(subcode_sync_flag), .SUBQ_DATA_I(sq), .LEVEL_DATA_I(lv),
        .SUBQ_LOAD_I(ctl[0]), .PW_DATA_I(pw), .PW_LOAD_I(ctl[1]), .SENSE_DATA_I(sd),
        .SENSE_LOAD_I(ctl[2]), .SENSE_LEVEL_I(ctl[3]), .DISC_DEFECT_I(ctl[4]),
        .FRAME_SYNC_DET_I(ctl[5]), .PROTECT_WINDOW_I(ctl[6]), .SYNC_S0_DET_I(ctl[7]),
        .SYNC_S1_DET_I(ctl[8]), .CMD_WORD_O(cmd_word), .CMD_STROBE_O(cmd_stb),
        .DEFECT_GUARD_O(dguard), .SYSTEM_RESET_O(sys_rst_o));

    cdsp_host_model host (.shift_clk_o(sclk), .data_o(sdat), .strobe_o(stb), .read_clk_o(rclk), .so_i(so));

    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        if (cmd_stb === 1'b1)
            n_stb++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic t_reset;
        chk(lock, 1'b0, "lock after reset");
        sys_rst_n <= 1'b0;
        cyc(6);
        chk(sys_rst_o, 1'b1, "pin reset");
        sys_rst_n <= 1'b1;
        cyc(6);
        chk(sys_rst_o, 1'b0, "pin reset release");
    endtask : t_reset
    task automatic t_cmd(input logic [23:0] w);
        int n0;
        n0 = n_stb;
        host.send_cmd(w);
        cyc(2);
        chk(cmd_word, w, "command word");
        chk(n_stb - n0, 1, "latch pulses");
    endtask : t_cmd
    task automatic t_read(input int sel, input int n, input logic [95:0] exp, input string what);
        logic [95:0] q;
        ctl[sel] <= 1'b1;
        cyc(1);
        ctl[sel] <= 1'b0;
        cyc(2);
        host.read_bits(sel, n, q);
        // back onto the rising edge so the next stimulus is an edge-aligned update
        cyc(1);
        chk(q, exp, what);
    endtask : t_read
    task automatic t_pairs(input int a, input int b, input bit is_and);
        for (int i = 0; i < 4; i++)
        begin
            ctl[a] <= i[0];
            if (is_and)
                dis <= i[1];
            else
                ctl[b] <= i[1];
            cyc(6);
            if (is_and)
                chk(dguard, i[0] & ~i[1], "defect guard");
            else
                chk(subcode_sync_flag, i[0] | i[1], "sync flag");
        end
    endtask : t_pairs
    // sample tick every 20 cycles; waits leave margin for tick phase
    task automatic t_lock;
        ctl[5] <= 1'b1;
        cyc(30);
        chk(lock, 1'b0, "lock outside window");
        ctl[6] <= 1'b1;
        cyc(30);
        chk(lock, 1'b1, "lock on good sample");
        ctl[5] <= 1'b0;
        cyc(120);
        chk(lock, 1'b1, "lock on short low run");
        ctl[5] <= 1'b1;
        cyc(30);
        ctl[5] <= 1'b0;
        cyc(185);
        chk(lock, 1'b0, "lock after eight lows");
    endtask : t_lock

    initial
    begin
        cyc(10);
        rst_n <= 1'b1;
        cyc(4);
        t_reset();
        t_cmd(24'hA5C3F0);
        t_cmd(24'h5A3C0F);
        t_read(0, 96, {sq, lv}, "sub-Q record");
        t_read(1, 8, pw, "P-W bits");
        t_read(2, 8, sd, "sense bits");
        chk(so[2], 1'b1, "sense level");
        ctl[3] <= 1'b0;
        cyc(4);
        chk(so[2], 1'b0, "sense level low");
        t_pairs(4, 0, 1'b1);
        t_pairs(7, 8, 1'b0);
        t_lock();
        test_done();
    end
    initial
    begin
        #200000;
        num_errors++;
        test_done();
    end
endmodule : cdsp_host_link_tb
